// [design/afs_cfg.svh]
`ifndef AFS_CFG_SVH
`define AFS_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define AFS_CTRL_OFFSET 12'h000
`define AFS_STATUS_OFFSET 12'h004
`define AFS_FRAMES_OFFSET 12'h008
`define AFS_LAST_OFFSET 12'h00c

// ----------------------------------------
// Control field positions and reset value
// ----------------------------------------
`define AFS_CTRL_FMT_BIT 0
`define AFS_CTRL_SCR_BIT 1
`define AFS_CTRL_PRE_BIT 2
`define AFS_CTRL_DITH_BIT 3
`define AFS_CTRL_PDA_BIT 4
`define AFS_CTRL_PDB_BIT 5
`define AFS_CTRL_RESET 6'h00

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define AFS_STAT_PRE_BIT 0
`define AFS_STAT_REQ_BIT 1
`define AFS_STAT_RD_BIT 2
`define AFS_STAT_OFF_BIT 3

// ----------------------------------------
// Line coding constants and frame timing
// ----------------------------------------
`define AFS_FRAME_BITS 5'h14
`define AFS_K28_5 8'hbc
`define AFS_D5_6 8'hc5
`define AFS_D16_2 8'h50
`define AFS_SCR_SEED 15'h7fff

`endif

// [design/afs_pkg.sv]
package afs_pkg;

    // Control bits set by software
    typedef struct packed {
        logic pd_b;
        logic pd_a;
        logic dither_en;
        logic preamble_style_select;
        logic scrambler_enable;
        logic data_format_select;
    } afs_ctrl_t;

    // One octet ahead of the line coder; k marks a control symbol
    typedef struct packed {
        logic k;
        logic [7:0] data;
    } afs_octet_t;

    // Scrambler result: new history and scrambled word
    typedef struct packed {
        logic [14:0] state;
        logic [15:0] word;
    } afs_scr_t;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_PREAMBLE,
        MODE_DATA
    } afs_mode_t;

endpackage : afs_pkg

// [design/afs_enc8b10b.sv]
`timescale 1ns/100ps
`default_nettype none

module afs_enc8b10b
    import afs_pkg::*;
(
    // Octet in
    input wire afs_octet_t octet,
    input wire logic rd_in,
    // Code group out, bit 0 is line bit a
    output logic [9:0] code,
    output logic rd_out
);

    function automatic logic [5:0] tab6(input logic [4:0] x);
        unique case (x)
            5'h00: tab6 = 6'b100111;
            5'h01: tab6 = 6'b011101;
            5'h02: tab6 = 6'b101101;
            5'h03: tab6 = 6'b110001;
            5'h04: tab6 = 6'b110101;
            5'h05: tab6 = 6'b101001;
            5'h06: tab6 = 6'b011001;
            5'h07: tab6 = 6'b111000;
            5'h08: tab6 = 6'b111001;
            5'h09: tab6 = 6'b100101;
            5'h0a: tab6 = 6'b010101;
            5'h0b: tab6 = 6'b110100;
            5'h0c: tab6 = 6'b001101;
            5'h0d: tab6 = 6'b101100;
            5'h0e: tab6 = 6'b011100;
            5'h0f: tab6 = 6'b010111;
            5'h10: tab6 = 6'b011011;
            5'h11: tab6 = 6'b100011;
            5'h12: tab6 = 6'b010011;
            5'h13: tab6 = 6'b110010;
            5'h14: tab6 = 6'b001011;
            5'h15: tab6 = 6'b101010;
            5'h16: tab6 = 6'b011010;
            5'h17: tab6 = 6'b111010;
            5'h18: tab6 = 6'b110011;
            5'h19: tab6 = 6'b100110;
            5'h1a: tab6 = 6'b010110;
            5'h1b: tab6 = 6'b110110;
            5'h1c: tab6 = 6'b001110;
            5'h1d: tab6 = 6'b101110;
            5'h1e: tab6 = 6'b011110;
            5'h1f: tab6 = 6'b101011;
        endcase
    endfunction : tab6

    function automatic logic [3:0] tab4(input logic [2:0] y);
        unique case (y)
            3'h0: tab4 = 4'b1011;
            3'h1: tab4 = 4'b1001;
            3'h2: tab4 = 4'b0101;
            3'h3: tab4 = 4'b1100;
            3'h4: tab4 = 4'b1101;
            3'h5: tab4 = 4'b1010;
            3'h6: tab4 = 4'b0110;
            3'h7: tab4 = 4'b1110;
        endcase
    endfunction : tab4

    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] b6;
    logic [3:0] b4;
    logic bal6;
    logic bal4;
    logic rd_mid;
    logic alt7;
    logic [9:0] cat;

    assign x = octet.data[4:0];
    assign y = octet.data[7:5];

    // Tables hold the negative-disparity form; complement for positive
    // Only K28.y is supported as a control symbol
    always_comb begin
        b6 = octet.k ? 6'b001111 : tab6(x);
        bal6 = ($countones(b6) == 3);
        if (rd_in && (!bal6 || (!octet.k && x == 5'h07))) begin
            b6 = ~b6;
        end
        rd_mid = bal6 ? rd_in : ~rd_in;
        alt7 = !octet.k && (y == 3'h7) &&
               ((!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
        b4 = alt7 ? 4'b0111 : tab4(y);
        bal4 = ($countones(b4) == 2);
        if (octet.k) begin
            if (bal4 ? !rd_mid : rd_mid) begin
                b4 = ~b4;
            end
        end else if (rd_mid && (!bal4 || y == 3'h3)) begin
            b4 = ~b4;
        end
        rd_out = bal4 ? rd_mid : ~rd_mid;
        cat = {b6, b4};
        for (int i = 0; i < 10; i++) begin
            code[i] = cat[9 - i];
        end
    end

endmodule : afs_enc8b10b

`default_nettype wire

// [design/afs_frame_tx.sv]
// Overview of operation
// - Format select low: offset binary, 0 is negative and 65535 positive full scale.
// - Format select high: two's complement, -32768 to 32767.
// - Both power-down bits set stop sampling and the serial output.
// - Each sample is split into octets, each coded as a 10-bit 8b/10b group.
// - Upper sample byte goes first in the frame, lower byte second.
// - Serial output starts with bit 0 of the first code group.
// - Scrambler enable applies 1 + x^14 + x^15 scrambling before coding.
// - Preamble starts only after sync request is held over one cycle.
// - Preamble style low: back-to-back K28.5 commas.
// - Preamble style high: idle sets, K28.5 then D5.6 or D16.2.
// - After request drops, preamble continues to the end of the frame.
// - Data characters start with the following frame.
// - With dither enabled the dither value is subtracted from each sample.
`timescale 1ns/100ps
`default_nettype none
`include "afs_cfg.svh"

module afs_frame_tx
    import afs_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SAMPLE_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Converter side
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic [SAMPLE_W-1:0] dither_value,
    output logic sample_take,
    // Serial link
    input wire logic sync_req,
    output logic serial_out,
    output logic frame_start
);

    // ----------------------------------------
    // Register bus decode
    // ----------------------------------------
    afs_ctrl_t ctrl;
    afs_mode_t mode;
    logic rd;
    logic sync_req_prev;
    logic [15:0] frame_count;
    logic [SAMPLE_W-1:0] last_word;

    wire access = psel & penable & ~pready;
    wire commit = psel & penable & pready;
    wire sel_ctrl = (paddr == ADDR_W'(`AFS_CTRL_OFFSET));
    wire sel_status = (paddr == ADDR_W'(`AFS_STATUS_OFFSET));
    wire sel_frames = (paddr == ADDR_W'(`AFS_FRAMES_OFFSET));
    wire sel_last = (paddr == ADDR_W'(`AFS_LAST_OFFSET));
    wire hit = sel_ctrl | sel_status | sel_frames | sel_last;
    wire ctrl_wr = commit & pwrite & sel_ctrl;

    wire [31:0] ctrl_word = 32'({ctrl.pd_b, ctrl.pd_a, ctrl.dither_en,
                                 ctrl.preamble_style_select, ctrl.scrambler_enable,
                                 ctrl.data_format_select});
    wire req_held = sync_req & sync_req_prev;
    wire shutdown = ctrl.pd_a & ctrl.pd_b;

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`AFS_STAT_PRE_BIT] = (mode == MODE_PREAMBLE);
        status_word[`AFS_STAT_REQ_BIT] = req_held;
        status_word[`AFS_STAT_RD_BIT] = rd;
        status_word[`AFS_STAT_OFF_BIT] = (mode == MODE_OFF);
    end

    wire [31:0] read_mux = sel_ctrl ? ctrl_word :
                           sel_status ? status_word :
                           sel_frames ? 32'(frame_count) :
                           sel_last ? 32'(last_word) : 32'h0000_0000;

    // ----------------------------------------
    // Register bus response
    // ----------------------------------------
    // One wait state: pready rises the cycle after the access phase opens,
    // and a write lands on the same edge the master sees pready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            prdata <= (access & ~pwrite) ? read_mux : 32'h0000_0000;
            pslverr <= access & ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= afs_ctrl_t'(`AFS_CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl.data_format_select <= pwdata[`AFS_CTRL_FMT_BIT];
            ctrl.scrambler_enable <= pwdata[`AFS_CTRL_SCR_BIT];
            ctrl.preamble_style_select <= pwdata[`AFS_CTRL_PRE_BIT];
            ctrl.dither_en <= pwdata[`AFS_CTRL_DITH_BIT];
            ctrl.pd_a <= pwdata[`AFS_CTRL_PDA_BIT];
            ctrl.pd_b <= pwdata[`AFS_CTRL_PDB_BIT];
        end
    end

    // ----------------------------------------
    // Sample formatting
    // ----------------------------------------
    wire [SAMPLE_W-1:0] dither_sub = ctrl.dither_en ? dither_value : '0;
    wire [SAMPLE_W-1:0] dithered = sample_in - dither_sub;
    // Offset binary is the native code; flipping the sign bit gives two's complement
    wire [SAMPLE_W-1:0] formatted = ctrl.data_format_select ?
        {~dithered[SAMPLE_W-1], dithered[SAMPLE_W-2:0]} : dithered;

    // ----------------------------------------
    // Scrambler
    // ----------------------------------------
    // Self-synchronising, so the seed only matters until the receiver
    // has seen fifteen scrambled bits.
    logic [14:0] scr_state;

    function automatic afs_scr_t scramble(input logic [15:0] d, input logic [14:0] st);
        afs_scr_t r;
        logic [14:0] h;
        logic b;
        h = st;
        r.word = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            b = d[i] ^ h[13] ^ h[14];
            r.word[i] = b;
            h = {h[13:0], b};
        end
        r.state = h;
        return r;
    endfunction : scramble

    afs_scr_t scr;
    assign scr = scramble(formatted, scr_state);
    wire [15:0] payload = ctrl.scrambler_enable ? scr.word : formatted;

    // ----------------------------------------
    // Frame content selection
    // ----------------------------------------
    logic [4:0] bit_cnt;
    wire frame_load = (bit_cnt == `AFS_FRAME_BITS - 5'h01);
    wire afs_mode_t next_mode = shutdown ? MODE_OFF :
                                req_held ? MODE_PREAMBLE : MODE_DATA;

    afs_octet_t oct [2];
    wire afs_octet_t comma = '{k: 1'b1, data: `AFS_K28_5};
    // Idle set second symbol: D16.2 flips the positive disparity left by K28.5 back, D5.6 keeps it
    wire afs_octet_t idle_data = '{k: 1'b0, data: rd ? `AFS_D5_6 : `AFS_D16_2};

    always_comb begin
        oct[0] = '{k: 1'b0, data: payload[15:8]};
        oct[1] = '{k: 1'b0, data: payload[7:0]};
        if (next_mode == MODE_PREAMBLE) begin
            oct[0] = comma;
            oct[1] = ctrl.preamble_style_select ? idle_data : comma;
        end
    end

    // ----------------------------------------
    // Line coding
    // ----------------------------------------
    logic [2:0] rd_chain;
    logic [9:0] group [2];
    assign rd_chain[0] = rd;

    for (genvar g = 0; g < 2; g++) begin : g_coder
        afs_enc8b10b u_coder (
            .octet(oct[g]),
            .rd_in(rd_chain[g]),
            .code(group[g]),
            .rd_out(rd_chain[g+1])
        );
    end

    wire [19:0] frame_word = {group[1], group[0]};

    // ----------------------------------------
    // Serialiser
    // ----------------------------------------
    logic [19:0] shifter;
    wire load_now = frame_load & ~shutdown;

    // Apart from shutdown, mode is only re-decided on a frame boundary, so a request that drops
    // mid-frame leaves the current preamble frame to finish.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= `AFS_FRAME_BITS - 5'h01;
            mode <= MODE_OFF;
            shifter <= 20'h00000;
            serial_out <= 1'b0;
            frame_start <= 1'b0;
            sample_take <= 1'b0;
        end else if (shutdown) begin
            bit_cnt <= `AFS_FRAME_BITS - 5'h01;
            mode <= MODE_OFF;
            serial_out <= 1'b0;
            frame_start <= 1'b0;
            sample_take <= 1'b0;
        end else if (load_now) begin
            bit_cnt <= 5'h00;
            mode <= next_mode;
            shifter <= {1'b0, frame_word[19:1]};
            serial_out <= frame_word[0];
            frame_start <= 1'b1;
            sample_take <= (next_mode == MODE_DATA);
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
            shifter <= {1'b0, shifter[19:1]};
            serial_out <= shifter[0];
            frame_start <= 1'b0;
            sample_take <= 1'b0;
        end
    end

    // ----------------------------------------
    // Disparity, scrambler history and status
    // ----------------------------------------
    wire data_load = load_now & (next_mode == MODE_DATA);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd <= 1'b0;
            sync_req_prev <= 1'b0;
            scr_state <= `AFS_SCR_SEED;
            frame_count <= 16'h0000;
            last_word <= '0;
        end else begin
            sync_req_prev <= sync_req;
            if (load_now) begin
                rd <= rd_chain[2];
                frame_count <= frame_count + 16'h0001;
            end
            if (data_load && ctrl.scrambler_enable) begin
                scr_state <= scr.state;
            end
            if (data_load) begin
                last_word <= formatted;
            end
        end
    end

endmodule : afs_frame_tx

`default_nettype wire

// [dv/afs_frame_tx_props.sv]
`timescale 1ns/100ps
`default_nettype none

module afs_frame_tx_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Serial link
    input wire logic sync_req,
    input wire logic serial_out,
    input wire logic frame_start,
    input wire logic sample_take
);
    // ----
    // Frame capture
    // ----
    logic [19:0] sh;
    logic [4:0] pos;
    logic held_r;
    logic take_r;
    // Judge a frame only when it ran whole, so shutdown cuts are ignored
    wire logic fe = frame_start && pos == 5'h14;
    wire logic k1 = sh[9:0] == 10'h17c || sh[9:0] == 10'h283;
    wire logic k2 = sh[19:10] == 10'h17c || sh[19:10] == 10'h283;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh <= 20'h0;
            pos <= 5'h1f;
            held_r <= 1'b0;
            take_r <= 1'b0;
        end else begin
            sh <= {serial_out, sh[19:1]};
            pos <= frame_start ? 5'h01 : (pos == 5'h1f ? pos : pos + 5'h01);
            if (frame_start) begin
                held_r <= $past(sync_req) && $past(sync_req, 2);
                take_r <= sample_take;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no answer after one wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error without ready or with data");
    property p_gap;
        frame_start |-> pos >= 5'h14;
    endproperty
    a_gap: assert property (p_gap) else $error("frame shorter than 20 bits");
    property p_take;
        sample_take |-> frame_start;
    endproperty
    a_take: assert property (p_take) else $error("sample taken off frame start");
    property p_bal;
        fe |-> $countones(sh[9:0]) inside {[4:6]} && $countones(sh[19:10]) inside {[4:6]};
    endproperty
    a_bal: assert property (p_bal) else $error("code group out of balance");
    property p_pre_hold;
        fe && k1 |-> held_r;
    endproperty
    a_pre_hold: assert property (p_pre_hold) else $error("preamble without held request");
    property p_hold_pre;
        fe && held_r |-> k1;
    endproperty
    a_hold_pre: assert property (p_hold_pre) else $error("held request without preamble");
    property p_data;
        fe |-> take_r == !k1;
    endproperty
    a_data: assert property (p_data) else $error("data frame and sample take disagree");
    property p_pair;
        fe && k1 |-> k2 || sh[15:10] inside {6'h25, 6'h36, 6'h09};
    endproperty
    a_pair: assert property (p_pair) else $error("bad second preamble group");
endmodule : afs_frame_tx_props

bind afs_frame_tx afs_frame_tx_props afs_frame_tx_props_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .sync_req(sync_req),
    .serial_out(serial_out),
    .frame_start(frame_start),
    .sample_take(sample_take)
);

`default_nettype wire

// [dv/afs_rx_model.sv]
`timescale 1ns/100ps
`default_nettype none

module afs_rx_model #(
    parameter int NEED = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Line side
    input wire logic serial_out,
    output logic sync_req,
    // Receiver control and capture
    input wire logic want_sync,
    input wire logic style,
    output logic [9:0] g1,
    output logic [9:0] g2,
    output logic [7:0] nfr
);
    logic [9:0] sh;
    logic [3:0] ph;
    logic [3:0] cnt;
    logic al;
    logic gpar;
    logic dg;
    logic want_d;
    wire logic [9:0] grp = {serial_out, sh[9:1]};
    wire logic k = grp == 10'h17c || grp == 10'h283;
    // Before alignment any comma window ends a group
    wire logic gend = al ? ph == 4'h9 : k;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sh, ph, cnt, al, gpar, dg, want_d, sync_req, g1, g2, nfr} <= '0;
        end else begin
            sh <= grp;
            want_d <= want_sync;
            ph <= gend ? 4'h0 : ph + 4'h1;
            if (want_sync && !want_d) begin
                al <= 1'b0;
                cnt <= 4'h0;
                sync_req <= 1'b1;
            end else if (gend) begin
                al <= 1'b1;
                if (k) begin
                    cnt <= cnt + 4'h1;
                    gpar <= style;
                    if (cnt == 4'(NEED - 1)) sync_req <= 1'b0;
                end else if (!gpar) begin
                    g1 <= grp;
                    gpar <= 1'b1;
                    dg <= 1'b1;
                end else begin
                    gpar <= 1'b0;
                    dg <= 1'b0;
                    if (dg) g2 <= grp;
                    if (dg) nfr <= nfr + 8'h01;
                end
            end
        end
    end
endmodule : afs_rx_model

`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "afs_cfg.svh"

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, sample_take, serial_out, frame_start, rx_sync, e;
    logic [15:0] sample_in = 16'h0000, dither_value = 16'h0000;
    logic want = 1'b0, style = 1'b0, pulse = 1'b0, any;
    logic [9:0] g1, g2;
    logic [7:0] nfr;
    int num_errors = 0, n_compared = 0, fs, ones;

    always #4 pclk = ~pclk;

    afs_frame_tx afs_frame_tx_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_in(sample_in),
        .dither_value(dither_value), .sample_take(sample_take),
        .sync_req(rx_sync | pulse), .serial_out(serial_out), .frame_start(frame_start));
    afs_rx_model afs_rx_model_inst (.pclk(pclk), .presetn(presetn),
        .serial_out(serial_out), .sync_req(rx_sync), .want_sync(want), .style(style),
        .g1(g1), .g2(g2), .nfr(nfr));

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        chk("apb answer", n < 50, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    task automatic count40();
        fs = 0;
        ones = 0;
        repeat (40) begin
            @(posedge pclk);
            fs += frame_start;
            ones += serial_out;
        end
    endtask : count40

    // Two whole frames must land in 40 cycles, the last holding the 00ff pattern
    task automatic data_ok(input string nm);
        logic [7:0] f0;
        f0 = nfr;
        cyc(40);
        chk(nm, 8'(nfr - f0), 8'h02);
        chk(nm, g1[5:0] == 6'h39 || g1[5:0] == 6'h06, 1);
        chk(nm, g2[5:0] == 6'h35 || g2[5:0] == 6'h0a, 1);
        $display("test %s done", nm);
    endtask : data_ok

    task automatic sync_up(input logic st);
        int n;
        style <= st;
        want <= 1'b1;
        cyc(3);
        n = 0;
        while (rx_sync !== 1'b0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        want <= 1'b0;
        chk("sync end", n < 2000, 1);
        cyc(60);
    endtask : sync_up

    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `AFS_CTRL_OFFSET, 0);
        chk("ctrl reset", q, 32'h0);
        chk("ctrl err", e, 0);
        apb(0, 12'h010, 0);
        chk("unmapped err", e, 1);
        chk("unmapped data", q, 32'h0);
        $display("test registers done");
        sample_in <= 16'h1234;
        dither_value <= 16'h0034;
        for (int i = 0; i < 4; i++) begin
            apb(1, `AFS_CTRL_OFFSET, {28'h0, i[1], 2'b00, i[0]});
            cyc(45);
            apb(0, `AFS_LAST_OFFSET, 0);
            chk("last word", q, {16'h0, (16'h1234 - (i[1] ? 16'h0034 : 16'h0)) ^ {i[0], 15'h0}});
        end
        $display("test word path done");
        sample_in <= 16'h00ff;
        dither_value <= 16'h0000;
        apb(1, `AFS_CTRL_OFFSET, 0);
        sync_up(0);
        data_ok("sync commas");
        apb(0, `AFS_STATUS_OFFSET, 0);
        chk("status after sync", q & 32'h3, 32'h0);
        apb(1, `AFS_CTRL_OFFSET, 4);
        sync_up(1);
        data_ok("sync idle sets");
        apb(1, `AFS_CTRL_OFFSET, 2);
        any = 1'b0;
        repeat (4) begin
            cyc(20);
            if (g1[5:0] !== 6'h39 && g1[5:0] !== 6'h06) any = 1'b1;
        end
        chk("scrambled", any, 1);
        $display("test scrambler done");
        apb(1, `AFS_CTRL_OFFSET, 0);
        cyc(40);
        repeat (3) begin
            pulse <= 1'b1;
            cyc(1);
            pulse <= 1'b0;
            cyc(9);
        end
        data_ok("short request");
        apb(1, `AFS_CTRL_OFFSET, 16);
        count40();
        chk("one power-down", fs, 2);
        apb(1, `AFS_CTRL_OFFSET, 48);
        // The cycle after the write still shows the bit launched before shutdown
        cyc(1);
        count40();
        chk("shutdown frames", fs, 0);
        chk("shutdown line", ones, 0);
        apb(0, `AFS_STATUS_OFFSET, 0);
        chk("shutdown status", q[3], 1);
        apb(1, `AFS_CTRL_OFFSET, 0);
        count40();
        chk("resume frames", fs, 2);
        $display("test shutdown done");
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
